//--- verilog/cgr_top.sv
// Function
// - offset word in three read-write bytes, 0Ah to 0Ch, reset zero
// - gain word in three read-write bytes, 0Dh to 0Fh, reset zero
// - register 10h bits 7:4 set pin direction, zero output, one input
// - register 10h bits 3:0 hold pin levels, input read or output drive
// - register 11h bits 3:0 pick analog input (zero) or digital pin (one)
module cgr_top #(
  parameter int ADDR_WIDTH = 8,
  parameter int NUM_PINS = 4,
  parameter int CAL_WIDTH = 24
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // shared pins
  input wire logic [NUM_PINS-1:0] gpio_in,
  output logic [NUM_PINS-1:0] gpio_out,
  output logic [NUM_PINS-1:0] gpio_oe,
  output logic [NUM_PINS-1:0] ain_enable,
  // calibration words to the conversion datapath
  output logic [CAL_WIDTH-1:0] offset_correction,
  output logic [CAL_WIDTH-1:0] gain_correction
);

  // the byte layout fixes pin count and word width
  if (NUM_PINS != cgr_pkg::NIB_W)
  begin : g_bad_pins
    $error("NUM_PINS must equal the nibble width");
  end
  if (CAL_WIDTH != cgr_pkg::BYTE_W * cgr_pkg::CAL_BYTES)
  begin : g_bad_cal
    $error("CAL_WIDTH must be three bytes");
  end
  if (ADDR_WIDTH < 7 || ADDR_WIDTH > 31)
  begin : g_bad_addr
    $error("ADDR_WIDTH must be 7 to 31");
  end

  // byte lanes of a calibration word
  localparam int LANE_LO = 0;
  localparam int LANE_MID = 1;
  localparam int LANE_HI = 2;

  // register selected by a bus address; unaligned words select nothing
  function automatic cgr_pkg::cgr_reg_t decode(
    input logic [ADDR_WIDTH-1:0] addr
  );
    logic [cgr_pkg::DATA_W-1:0] a;
    a = {{(cgr_pkg::DATA_W-ADDR_WIDTH){1'b0}}, addr};
    if (a == cgr_pkg::byte_addr(cgr_pkg::IDX_OFS_LO))
      decode = cgr_pkg::REG_OFS_LO;
    else if (a == cgr_pkg::byte_addr(cgr_pkg::IDX_OFS_MID))
      decode = cgr_pkg::REG_OFS_MID;
    else if (a == cgr_pkg::byte_addr(cgr_pkg::IDX_OFS_HI))
      decode = cgr_pkg::REG_OFS_HI;
    else if (a == cgr_pkg::byte_addr(cgr_pkg::IDX_GAIN_LO))
      decode = cgr_pkg::REG_GAIN_LO;
    else if (a == cgr_pkg::byte_addr(cgr_pkg::IDX_GAIN_MID))
      decode = cgr_pkg::REG_GAIN_MID;
    else if (a == cgr_pkg::byte_addr(cgr_pkg::IDX_GAIN_HI))
      decode = cgr_pkg::REG_GAIN_HI;
    else if (a == cgr_pkg::byte_addr(cgr_pkg::IDX_PIN_DIR_LVL))
      decode = cgr_pkg::REG_PIN_DIR_LVL;
    else if (a == cgr_pkg::byte_addr(cgr_pkg::IDX_PIN_SEL))
      decode = cgr_pkg::REG_PIN_SEL;
    else
      decode = cgr_pkg::REG_NONE;
  endfunction

  // replace one byte lane of a calibration word
  function automatic logic [CAL_WIDTH-1:0] put_byte(
    input logic [CAL_WIDTH-1:0] word,
    input int lane,
    input logic [7:0] data
  );
    logic [CAL_WIDTH-1:0] w;
    w = word;
    w[lane*cgr_pkg::BYTE_W +: cgr_pkg::BYTE_W] = data;
    put_byte = w;
  endfunction

  // one byte lane of a calibration word
  function automatic logic [7:0] get_byte(
    input logic [CAL_WIDTH-1:0] word,
    input int lane
  );
    get_byte = word[lane*cgr_pkg::BYTE_W +: cgr_pkg::BYTE_W];
  endfunction

  cgr_pin_if #(.NUM_PINS(NUM_PINS)) pin_bus ();

  // bus slave state
  cgr_pkg::cgr_state_t state_q;
  cgr_pkg::cgr_state_t state_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;

  // register file
  logic [CAL_WIDTH-1:0] ofs_q;
  logic [CAL_WIDTH-1:0] ofs_d;
  logic [CAL_WIDTH-1:0] gain_q;
  logic [CAL_WIDTH-1:0] gain_d;
  logic [NUM_PINS-1:0] dir_q;
  logic [NUM_PINS-1:0] dir_d;
  logic [NUM_PINS-1:0] lvl_q;
  logic [NUM_PINS-1:0] lvl_d;
  logic [NUM_PINS-1:0] dsel_q;
  logic [NUM_PINS-1:0] dsel_d;

  cgr_pkg::cgr_reg_t sel;
  logic wr_en;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic [NUM_PINS-1:0] lvl_view;

  assign sel = decode(paddr);
  assign wbyte = pwdata[7:0];

  // level shows the pin for digital inputs, the stored bit otherwise
  assign lvl_view = (dsel_q & dir_q & pin_bus.pin_level)
    | (~(dsel_q & dir_q) & lvl_q);

  always_comb
  begin
    rbyte = cgr_pkg::RST_BYTE;
    case (sel)
      cgr_pkg::REG_OFS_LO:
        rbyte = get_byte(ofs_q, LANE_LO);
      cgr_pkg::REG_OFS_MID:
        rbyte = get_byte(ofs_q, LANE_MID);
      cgr_pkg::REG_OFS_HI:
        rbyte = get_byte(ofs_q, LANE_HI);
      cgr_pkg::REG_GAIN_LO:
        rbyte = get_byte(gain_q, LANE_LO);
      cgr_pkg::REG_GAIN_MID:
        rbyte = get_byte(gain_q, LANE_MID);
      cgr_pkg::REG_GAIN_HI:
        rbyte = get_byte(gain_q, LANE_HI);
      cgr_pkg::REG_PIN_DIR_LVL:
      begin
        rbyte[cgr_pkg::DIR_LO +: cgr_pkg::NIB_W] = dir_q;
        rbyte[cgr_pkg::LVL_LO +: cgr_pkg::NIB_W] = lvl_view;
      end
      cgr_pkg::REG_PIN_SEL:
      begin
        // upper nibble stays zero
        rbyte[cgr_pkg::SEL_LO +: cgr_pkg::NIB_W] = dsel_q;
      end
      default: rbyte = cgr_pkg::RST_BYTE;
    endcase
  end

  // bus handshake: answer one cycle into the access phase
  always_comb
  begin
    state_d = state_q;
    pready_d = 1'b0;
    pslverr_d = pslverr_q;
    prdata_d = prdata_q;
    case (state_q)
      cgr_pkg::ST_IDLE:
      begin
        if (psel && penable)
        begin
          state_d = cgr_pkg::ST_ACK;
          pready_d = 1'b1;
          pslverr_d = (sel == cgr_pkg::REG_NONE);
          prdata_d = pwrite ? 32'h0000_0000 : {24'h00_0000, rbyte};
        end
      end
      cgr_pkg::ST_ACK:
      begin
        state_d = cgr_pkg::ST_IDLE;
      end
      default:
      begin
        state_d = cgr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= cgr_pkg::ST_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      state_q <= state_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // a write lands at the edge where the master sees pready high
  assign wr_en = (state_q == cgr_pkg::ST_ACK) && psel && penable && pwrite
    && !pslverr_q && pstrb[0];

  always_comb
  begin
    ofs_d = ofs_q;
    gain_d = gain_q;
    dir_d = dir_q;
    lvl_d = lvl_q;
    dsel_d = dsel_q;
    if (wr_en)
    begin
      case (sel)
        cgr_pkg::REG_OFS_LO:
          ofs_d = put_byte(ofs_q, LANE_LO, wbyte);
        cgr_pkg::REG_OFS_MID:
          ofs_d = put_byte(ofs_q, LANE_MID, wbyte);
        cgr_pkg::REG_OFS_HI:
          ofs_d = put_byte(ofs_q, LANE_HI, wbyte);
        cgr_pkg::REG_GAIN_LO:
          gain_d = put_byte(gain_q, LANE_LO, wbyte);
        cgr_pkg::REG_GAIN_MID:
          gain_d = put_byte(gain_q, LANE_MID, wbyte);
        cgr_pkg::REG_GAIN_HI:
          gain_d = put_byte(gain_q, LANE_HI, wbyte);
        cgr_pkg::REG_PIN_DIR_LVL:
        begin
          dir_d = wbyte[cgr_pkg::DIR_LO +: cgr_pkg::NIB_W];
          lvl_d = wbyte[cgr_pkg::LVL_LO +: cgr_pkg::NIB_W];
        end
        cgr_pkg::REG_PIN_SEL:
        begin
          // upper nibble is dropped, never stored
          dsel_d = wbyte[cgr_pkg::SEL_LO +: cgr_pkg::NIB_W];
        end
        default:
        begin
          dsel_d = dsel_q;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ofs_q <= '0;
      gain_q <= '0;
      dir_q <= cgr_pkg::RST_NIBBLE;
      lvl_q <= cgr_pkg::RST_NIBBLE;
      dsel_q <= cgr_pkg::RST_NIBBLE;
    end
    else
    begin
      ofs_q <= ofs_d;
      gain_q <= gain_d;
      dir_q <= dir_d;
      lvl_q <= lvl_d;
      dsel_q <= dsel_d;
    end
  end

  assign pin_bus.dir = dir_q;
  assign pin_bus.level = lvl_q;
  assign pin_bus.dsel = dsel_q;

  cgr_pin_ctrl #(
    .NUM_PINS(NUM_PINS)
  ) u_pins (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .cfg(pin_bus.ctrl),
    .gpio_in(gpio_in),
    .gpio_out(gpio_out),
    .gpio_oe(gpio_oe),
    .ain_enable(ain_enable)
  );

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign offset_correction = ofs_q;
  assign gain_correction = gain_q;

endmodule

//--- inc/cgr_pkg.sv
package cgr_pkg;

  // register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_OFS_LO = 8'h0A;
  localparam logic [7:0] IDX_OFS_MID = 8'h0B;
  localparam logic [7:0] IDX_OFS_HI = 8'h0C;
  localparam logic [7:0] IDX_GAIN_LO = 8'h0D;
  localparam logic [7:0] IDX_GAIN_MID = 8'h0E;
  localparam logic [7:0] IDX_GAIN_HI = 8'h0F;
  localparam logic [7:0] IDX_PIN_DIR_LVL = 8'h10;
  localparam logic [7:0] IDX_PIN_SEL = 8'h11;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIBBLE = 4'h0;

  // field layout of the byte registers
  localparam int BYTE_W = 8;
  localparam int NIB_W = 4;
  localparam int DIR_LO = 4;
  localparam int LVL_LO = 0;
  localparam int SEL_LO = 0;
  localparam int CAL_BYTES = 3;

  // register word width on the bus
  localparam int DATA_W = 32;

  // which register an access selects
  typedef enum logic [3:0] {
    REG_NONE = 4'b0000,
    REG_OFS_LO = 4'b0001,
    REG_OFS_MID = 4'b0010,
    REG_OFS_HI = 4'b0011,
    REG_GAIN_LO = 4'b0100,
    REG_GAIN_MID = 4'b0101,
    REG_GAIN_HI = 4'b0110,
    REG_PIN_DIR_LVL = 4'b0111,
    REG_PIN_SEL = 4'b1000
  } cgr_reg_t;

  // bus slave phase
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACK = 2'b01
  } cgr_state_t;

  // byte address of a register index
  function automatic logic [DATA_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = {22'h000000, idx, 2'b00};
  endfunction

endpackage

//--- inc/cgr_pin_if.sv
interface cgr_pin_if #(parameter int NUM_PINS = 4);
  // register side settings
  logic [NUM_PINS-1:0] dir;
  logic [NUM_PINS-1:0] level;
  logic [NUM_PINS-1:0] dsel;
  // sampled pin levels
  logic [NUM_PINS-1:0] pin_level;

  modport regs (
    output dir,
    output level,
    output dsel,
    input pin_level
  );

  modport ctrl (
    input dir,
    input level,
    input dsel,
    output pin_level
  );
endinterface

//--- verilog/cgr_pin_ctrl.sv
module cgr_pin_ctrl #(
  parameter int NUM_PINS = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // settings from the register file
  cgr_pin_if.ctrl cfg,
  // shared pins
  input wire logic [NUM_PINS-1:0] gpio_in,
  output logic [NUM_PINS-1:0] gpio_out,
  output logic [NUM_PINS-1:0] gpio_oe,
  output logic [NUM_PINS-1:0] ain_enable
);

  logic [NUM_PINS-1:0] out_q;
  logic [NUM_PINS-1:0] out_d;
  logic [NUM_PINS-1:0] oe_q;
  logic [NUM_PINS-1:0] oe_d;
  logic [NUM_PINS-1:0] ain_q;
  logic [NUM_PINS-1:0] ain_d;
  logic [NUM_PINS-1:0] in_q;
  logic [NUM_PINS-1:0] in_d;

  always_comb
  begin
    // drive only digital pins set as outputs
    oe_d = cfg.dsel & ~cfg.dir;
    // level register sets the driven level
    out_d = cfg.level & oe_d;
    // zero select keeps the pin on the analog input
    ain_d = ~cfg.dsel;
    in_d = gpio_in;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      out_q <= '0;
      oe_q <= '0;
      ain_q <= '1;
      in_q <= '0;
    end
    else
    begin
      out_q <= out_d;
      oe_q <= oe_d;
      ain_q <= ain_d;
      in_q <= in_d;
    end
  end

  assign gpio_out = out_q;
  assign gpio_oe = oe_q;
  assign ain_enable = ain_q;
  assign cfg.pin_level = in_q;

endmodule

//--- verification/cgr_top_properties.sv
module cgr_top_properties #(
  parameter int ADDR_WIDTH = 8,
  parameter int NUM_PINS = 4,
  parameter int CAL_WIDTH = 24
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins and calibration words
  input wire logic [NUM_PINS-1:0] gpio_in,
  input wire logic [NUM_PINS-1:0] gpio_out,
  input wire logic [NUM_PINS-1:0] gpio_oe,
  input wire logic [NUM_PINS-1:0] ain_enable,
  input wire logic [CAL_WIDTH-1:0] offset_correction,
  input wire logic [CAL_WIDTH-1:0] gain_correction
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  logic wr;
  // a write that takes effect at this edge
  assign wr = psel && penable && pready && pwrite && pstrb[0];
  a_ack_next: assert property (psel && penable && !pready |=> pready)
    else $error("late answer");
  a_ack_pulse: assert property (pready |=> !pready)
    else $error("answer held");
  a_ofs_lo_write: assert property (wr && paddr == 8'h28 |=>
    offset_correction[7:0] == $past(pwdata[7:0])) else $error("offset lo");
  a_gain_hi_write: assert property (wr && paddr == 8'h3C |=>
    gain_correction[23:16] == $past(pwdata[7:0])) else $error("gain hi");
  a_sel_to_ain: assert property (wr && paddr == 8'h44 |=> ##1
    ain_enable == ~$past(pwdata[3:0], 2)) else $error("analog select");
  a_dir_to_oe: assert property (wr && paddr == 8'h40 |=> ##1
    gpio_oe == (~$past(pwdata[7:4], 2) & ~ain_enable)) else $error("dir");
  a_lvl_to_out: assert property (wr && paddr == 8'h40 |=> ##1
    gpio_out == ($past(pwdata[3:0], 2) & gpio_oe)) else $error("level");
  a_oe_digital: assert property ((gpio_oe & ain_enable) == 4'h0)
    else $error("analog pin driven");
  a_rsvd_read: assert property (pready && !pwrite &&
    paddr == 8'h44 |-> prdata[31:4] == 28'h0)
    else $error("reserved bits set");
  c_ofs_write: cover property (wr && paddr == 8'h28);
  c_pin_write: cover property (wr && paddr == 8'h40);
  c_error: cover property (pready && pslverr);
endmodule

bind cgr_top cgr_top_properties #(.ADDR_WIDTH(ADDR_WIDTH),
  .NUM_PINS(NUM_PINS), .CAL_WIDTH(CAL_WIDTH)) cgr_top_properties_inst (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .gpio_in(gpio_in),
  .gpio_out(gpio_out), .gpio_oe(gpio_oe), .ain_enable(ain_enable),
  .offset_correction(offset_correction), .gain_correction(gain_correction));

//--- verification/cgr_pin_model.sv
module cgr_pin_model #(
  parameter int NUM_PINS = 4
) (
  // device side of the pins
  input wire logic [NUM_PINS-1:0] gpio_out,
  input wire logic [NUM_PINS-1:0] gpio_oe,
  // level the far lines put on released pins
  input wire logic [NUM_PINS-1:0] ext_level,
  // resolved pin level
  output logic [NUM_PINS-1:0] gpio_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // far lines drive only where the device has released the pin
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_level);
endmodule

//--- verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, er;
  logic [3:0] gpio_in, gpio_out, gpio_oe, ain_enable, ext_level = 4'h0;
  logic [3:0] sel, dir, lvl, x;
  logic [23:0] offset_correction, gain_correction;
  logic [7:0] cal [6];
  logic [15:0] cor [4] = '{16'hF0F0, 16'hFF0A, 16'h00F5, 16'h5A3C};
  logic [31:0] seed = 32'd70928;
  int err_count = 0, comparisons = 0, cycles = 0;

  always #10 ref_clk = ~ref_clk;

  cgr_top cgr_top_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .ain_enable(ain_enable), .offset_correction(offset_correction),
    .gain_correction(gain_correction));
  cgr_pin_model cgr_pin_model_inst (.gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .ext_level(ext_level), .gpio_in(gpio_in));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // a digital input reads the line, every other pin its stored bit
  function automatic logic [3:0] lvl_exp(input logic [3:0] s, d, l, e);
    lvl_exp = (s & d & e) | (~(s & d) & l);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
      @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic test_done;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      test_done();
    end
  end

  initial
  begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, 8'h28 + 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    chk(32'({ain_enable, gpio_oe}), 32'hF0);
    repeat (2)
    begin
      for (int i = 0; i < 6; i++)
      begin
        seed = lfsr(seed);
        cal[i] = seed[7:0];
        apb(1'b1, 8'h28 + 8'(4 * i), seed);
      end
      for (int i = 0; i < 6; i++)
      begin
        apb(1'b0, 8'h28 + 8'(4 * i), 32'h0);
        chk(rd, {24'h0, cal[i]});
      end
      chk(32'(offset_correction), {8'h0, cal[2], cal[1], cal[0]});
      chk(32'(gain_correction), {8'h0, cal[5], cal[4], cal[3]});
    end
    // corner settings first, then random ones
    for (int k = 0; k < 12; k++)
    begin
      seed = lfsr(seed);
      {sel, dir, lvl, x} = (k < 4) ? cor[k] : seed[15:0];
      apb(1'b1, 8'h44, {28'h0, sel});
      apb(1'b1, 8'h40, {24'h0, dir, lvl});
      ext_level <= x;
      repeat (3) @(posedge ref_clk);
      chk(32'({ain_enable, gpio_oe, gpio_out}),
        32'({~sel, sel & ~dir, lvl & sel & ~dir}));
      apb(1'b0, 8'h40, 32'h0);
      chk(rd, {24'h0, dir, lvl_exp(sel, dir, lvl, x)});
      apb(1'b0, 8'h44, 32'h0);
      chk(rd, {28'h0, sel});
    end
    // unmapped and unaligned places answer with an error
    apb(1'b0, 8'h48, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, 8'h29, 32'hFF);
    chk(32'(er), 32'h1);
    // a write with the low byte strobe clear changes nothing
    pstrb <= 4'hE;
    apb(1'b1, 8'h28, {24'h0, ~cal[0]});
    pstrb <= 4'hF;
    apb(1'b0, 8'h28, 32'h0);
    chk(rd, {24'h0, cal[0]});
    test_done();
  end
endmodule
